// ---- inc/smpm_defines.svh ----
// constants of the sleep mode power manager: offsets, fields, resets, timing
`ifndef SMPM_DEFINES_SVH
`define SMPM_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SMPM_CLK_PERIOD_NS 40
`define SMPM_CHECK_TIME_US 2300
`define SMPM_CHECK_CYCLES ((`SMPM_CHECK_TIME_US * 1000) / `SMPM_CLK_PERIOD_NS)
`define SMPM_TICK_TIME_US 1000
`define SMPM_TICK_CYCLES ((`SMPM_TICK_TIME_US * 1000) / `SMPM_CLK_PERIOD_NS)

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SMPM_CTRL_OFS 12'h000
`define SMPM_STAT_OFS 12'h004
`define SMPM_IRQ_STAT_OFS 12'h008
`define SMPM_IRQ_MASK_OFS 12'h00c
`define SMPM_REST_OFS 12'h010
`define SMPM_LVL_BASE_OFS 12'h020
`define SMPM_LVL_STRIDE 12'h010
`define SMPM_LVL_SLEEP_OFS 12'h000
`define SMPM_LVL_THR_OFS 12'h004
`define SMPM_LVL_MODE_OFS 12'h008

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SMPM_CTRL_LP_BIT 0
`define SMPM_IRQ_WAKE_BIT 0
`define SMPM_IRQ_MOTION_BIT 1
`define SMPM_IRQ_STEP_BIT 2
`define SMPM_IRQ_W 3
`define SMPM_SLEEP_RST 16'h0064
`define SMPM_THR_RST 16'h0001
`define SMPM_MODE_RST 16'h03e8
`define SMPM_REST_RST 16'h0064

`endif

// ---- inc/smpm_pkg.sv ----
// types of the sleep mode power manager
package smpm_pkg;

	// ****************************************************************
	// power states, per-level settings and level register address decode
	// ****************************************************************
	typedef enum logic [2:0] {
		SMPM_TRACK = 3'b001,
		SMPM_INACT = 3'b010,
		SMPM_CHECK = 3'b100
	} smpm_state_t;

	typedef struct packed {
		logic [15:0] sleep_time;
		logic [15:0] thresh;
		logic [15:0] mode_time;
	} smpm_level_t;

	typedef struct packed {
		logic hit;
		logic [1:0] level;
		logic [1:0] field;
	} smpm_lvl_sel_t;

endpackage : smpm_pkg

// ---- core/smpm_core.sv ----
// sleep mode power manager with apb register slave
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "smpm_defines.svh"
module smpm_core #(
	parameter int unsigned CHECK_CYCLES = `SMPM_CHECK_CYCLES,
	parameter int unsigned TICK_CYCLES = `SMPM_TICK_CYCLES,
	parameter int unsigned LEVELS = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensor side
	input wire logic [15:0] motion_mag,
	output logic sensor_on,
	output logic [1:0] sleep_level,
	// interrupt
	output logic irq
);

	// ****************************************************************
	// decode
	// ****************************************************************
	function automatic smpm_pkg::smpm_lvl_sel_t lvl_decode(input logic [11:0] a);
		smpm_pkg::smpm_lvl_sel_t s;
		logic [11:0] rel;
		rel = a - `SMPM_LVL_BASE_OFS;
		s.hit = (a >= `SMPM_LVL_BASE_OFS) && (rel < (`SMPM_LVL_STRIDE * 12'h004))
			&& (12'(rel[3:0]) <= `SMPM_LVL_MODE_OFS) && (rel[1:0] == 2'h0);
		s.level = rel[5:4];
		s.field = rel[3:2];
		return s;
	endfunction : lvl_decode
	localparam int unsigned CW = $clog2(CHECK_CYCLES + 1);
	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

	// ****************************************************************
	// state
	// ****************************************************************
	smpm_pkg::smpm_state_t state, next_state;
	smpm_pkg::smpm_level_t cfg [LEVELS];
	smpm_pkg::smpm_level_t next_cfg [LEVELS];
	logic lp_en, next_lp_en;
	logic [15:0] rest_time, next_rest_time;
	logic [`SMPM_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, ev;
	logic [1:0] level, next_level;
	logic [15:0] rest_ms, next_rest_ms, sleep_ms, next_sleep_ms, mode_ms, next_mode_ms;
	logic [16:0] accum, next_accum;
	logic [CW-1:0] check_cnt, next_check_cnt;
	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic [31:0] next_prdata;
	logic tick, check_last, wr, rd;
	smpm_pkg::smpm_lvl_sel_t sel;
	smpm_pkg::smpm_level_t cur;

	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign sel = lvl_decode(paddr);
	assign cur = cfg[level];
	assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));
	assign check_last = (check_cnt == CW'(CHECK_CYCLES - 1));
	assign sensor_on = (state != smpm_pkg::SMPM_INACT);
	assign sleep_level = level;
	assign irq = |(irq_stat & irq_mask);

	// unmapped addresses answer with an error but never stall the bus
	always_comb
	begin
		pslverr = 1'b0;
		if (psel && penable)
		begin
			case (paddr)
				`SMPM_CTRL_OFS, `SMPM_STAT_OFS, `SMPM_IRQ_STAT_OFS,
				`SMPM_IRQ_MASK_OFS, `SMPM_REST_OFS: pslverr = 1'b0;
				default: pslverr = !sel.hit;
			endcase
		end
	end

	// ****************************************************************
	// registers and read data
	// ****************************************************************
	always_comb
	begin
		next_lp_en = lp_en;
		next_rest_time = rest_time;
		next_irq_mask = irq_mask;
		next_cfg = cfg;
		next_prdata = prdata;
		if (wr)
		begin
			case (paddr)
				`SMPM_CTRL_OFS: next_lp_en = pwdata[`SMPM_CTRL_LP_BIT];
				`SMPM_IRQ_MASK_OFS: next_irq_mask = pwdata[`SMPM_IRQ_W-1:0];
				`SMPM_REST_OFS: next_rest_time = pwdata[15:0];
				default:
				begin
					if (sel.hit)
					begin
						case (sel.field)
							2'h0: next_cfg[sel.level].sleep_time = pwdata[15:0];
							2'h1: next_cfg[sel.level].thresh = pwdata[15:0];
							default: next_cfg[sel.level].mode_time = pwdata[15:0];
						endcase
					end
				end
			endcase
		end
		// read data is latched in the setup cycle so it comes from a flop
		if (rd)
		begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				`SMPM_CTRL_OFS: next_prdata[`SMPM_CTRL_LP_BIT] = lp_en;
				`SMPM_STAT_OFS: next_prdata = {24'h00_0000, 1'b0, sensor_on, level, 1'b0, state};
				`SMPM_IRQ_STAT_OFS: next_prdata[`SMPM_IRQ_W-1:0] = irq_stat;
				`SMPM_IRQ_MASK_OFS: next_prdata[`SMPM_IRQ_W-1:0] = irq_mask;
				`SMPM_REST_OFS: next_prdata[15:0] = rest_time;
				default:
				begin
					if (sel.hit)
					begin
						case (sel.field)
							2'h0: next_prdata[15:0] = cfg[sel.level].sleep_time;
							2'h1: next_prdata[15:0] = cfg[sel.level].thresh;
							default: next_prdata[15:0] = cfg[sel.level].mode_time;
						endcase
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// power sequencer
	// ****************************************************************
	always_comb
	begin
		next_state = state;
		next_level = level;
		next_rest_ms = rest_ms;
		next_sleep_ms = sleep_ms;
		next_mode_ms = mode_ms;
		next_accum = accum;
		next_check_cnt = check_cnt;
		ev = '0;
		// the ms timer free-runs so the wake timer keeps going while inactive
		next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
		case (state)
			smpm_pkg::SMPM_TRACK:
			begin
				if (!lp_en || motion_mag != 16'h0000)
					next_rest_ms = 16'h0000;
				else if (tick && rest_ms != 16'hffff)
					next_rest_ms = rest_ms + 16'h0001;
				if (lp_en && rest_ms >= rest_time)
				begin
					next_state = smpm_pkg::SMPM_INACT;
					next_level = 2'h0;
					next_sleep_ms = 16'h0000;
					next_mode_ms = 16'h0000;
				end
			end
			smpm_pkg::SMPM_INACT:
			begin
				if (tick)
					next_sleep_ms = sleep_ms + 16'h0001;
				if (tick && next_sleep_ms >= cur.sleep_time)
				begin
					next_state = smpm_pkg::SMPM_CHECK;
					next_check_cnt = '0;
					next_accum = 17'h0_0000;
					ev[`SMPM_IRQ_WAKE_BIT] = 1'b1;
				end
			end
			smpm_pkg::SMPM_CHECK:
			begin
				next_check_cnt = check_cnt + CW'(1);
				next_accum = accum[16] ? accum : accum + {1'b0, motion_mag};
				if (check_last)
				begin
					if (accum >= {1'b0, cur.thresh})
					begin
						next_state = smpm_pkg::SMPM_TRACK;
						next_rest_ms = 16'h0000;
						ev[`SMPM_IRQ_MOTION_BIT] = 1'b1;
					end
					else
					begin
						next_state = smpm_pkg::SMPM_INACT;
						next_sleep_ms = 16'h0000;
					end
				end
			end
			default: next_state = smpm_pkg::SMPM_TRACK;
		endcase
		// level stepping runs in hardware over inactive and check time
		if (state != smpm_pkg::SMPM_TRACK && tick)
		begin
			if (mode_ms + 16'h0001 >= cur.mode_time && level != 2'(LEVELS - 1))
			begin
				next_level = level + 2'h1;
				next_mode_ms = 16'h0000;
				ev[`SMPM_IRQ_STEP_BIT] = 1'b1;
			end
			else if (mode_ms != 16'hffff)
				next_mode_ms = mode_ms + 16'h0001;
		end
		if (!lp_en)
			next_state = smpm_pkg::SMPM_TRACK;
		// a new event wins over a clear in the same cycle
		next_irq_stat = irq_stat;
		if (wr && paddr == `SMPM_IRQ_STAT_OFS)
			next_irq_stat = irq_stat & ~pwdata[`SMPM_IRQ_W-1:0];
		next_irq_stat = next_irq_stat | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= smpm_pkg::SMPM_TRACK;
			level <= 2'h0;
			rest_ms <= 16'h0000;
			sleep_ms <= 16'h0000;
			mode_ms <= 16'h0000;
			accum <= 17'h0_0000;
			check_cnt <= '0;
			tick_cnt <= '0;
			lp_en <= 1'b0;
			rest_time <= `SMPM_REST_RST;
			irq_stat <= '0;
			irq_mask <= '0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			state <= next_state;
			level <= next_level;
			rest_ms <= next_rest_ms;
			sleep_ms <= next_sleep_ms;
			mode_ms <= next_mode_ms;
			accum <= next_accum;
			check_cnt <= next_check_cnt;
			tick_cnt <= next_tick_cnt;
			lp_en <= next_lp_en;
			rest_time <= next_rest_time;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			prdata <= next_prdata;
		end
	end

	// LEVELS separate setting sets, one flop group per level
	for (genvar g = 0; g < LEVELS; g++)
	begin : g_lvl
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				cfg[g] <= {`SMPM_SLEEP_RST, `SMPM_THR_RST, `SMPM_MODE_RST};
			else
				cfg[g] <= next_cfg[g];
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence enter_check_s;
		(state == smpm_pkg::SMPM_INACT) ##1 (state == smpm_pkg::SMPM_CHECK);
	endsequence
	sequence check_end_s;
		(state == smpm_pkg::SMPM_CHECK) && check_last && lp_en;
	endsequence

	lp_off_track_a: assert property (!lp_en |=> state == smpm_pkg::SMPM_TRACK)
		else $error("tracking left while low power disabled");
	inact_sensor_off_a: assert property (state == smpm_pkg::SMPM_INACT |-> !sensor_on)
		else $error("sensor on while inactive");
	wake_irq_set_a: assert property (enter_check_s |-> irq_stat[`SMPM_IRQ_WAKE_BIT])
		else $error("wake timer left no interrupt");
	rest_to_inact_a: assert property (state == smpm_pkg::SMPM_TRACK && lp_en
		&& rest_ms >= rest_time |=> state == smpm_pkg::SMPM_INACT && level == 2'h0)
		else $error("rest expiry did not enter sleep");
	inact_hold_a: assert property (state == smpm_pkg::SMPM_INACT && lp_en && !tick
		|=> state == smpm_pkg::SMPM_INACT)
		else $error("inactive left between ticks");
	check_hold_a: assert property (state == smpm_pkg::SMPM_CHECK && !check_last && lp_en
		|=> state == smpm_pkg::SMPM_CHECK && check_cnt == $past(check_cnt) + CW'(1))
		else $error("check ended early");
	motion_wake_a: assert property (check_end_s and (accum >= {1'b0, cur.thresh})
		|=> state == smpm_pkg::SMPM_TRACK && irq_stat[`SMPM_IRQ_MOTION_BIT])
		else $error("motion did not wake");
	no_motion_back_a: assert property (check_end_s and (accum < {1'b0, cur.thresh})
		|=> state == smpm_pkg::SMPM_INACT && sleep_ms == 16'h0000)
		else $error("no motion did not return inactive");
	deep_hold_a: assert property (level == 2'(LEVELS - 1) && lp_en
		&& state != smpm_pkg::SMPM_TRACK |=> level == 2'(LEVELS - 1))
		else $error("deepest level left while asleep");
	step_one_a: assert property ($past(state) != smpm_pkg::SMPM_TRACK
		&& level != $past(level) |-> level == $past(level) + 2'h1
		&& irq_stat[`SMPM_IRQ_STEP_BIT])
		else $error("level step wrong");

endmodule : smpm_core

// ---- bench/tb_smpm_core.sv ----
// self-checking testbench of the sleep mode power manager
`timescale 1ns/1ps
`include "smpm_defines.svh"
module tb_smpm_core;
	// short counts keep the run brief
	localparam int CHK = 20;
	localparam int TCK = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sensor_on, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] motion_mag;
	logic [1:0] sleep_level;
	logic e;
	int error_cnt = 0;
	int checks_done = 0;

	smpm_core #(.CHECK_CYCLES(CHK), .TICK_CYCLES(TCK), .LEVELS(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .motion_mag(motion_mag), .sensor_on(sensor_on),
		.sleep_level(sleep_level), .irq(irq));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task bail(input string what);
		error_cnt++;
		$display("unexpected at %0t: timeout %s", $time, what);
		test_done;
	endtask : bail

	// apb transfer; holds the request until pready is seen high
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
				bail("pready");
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(a, 1'b0, 32'h0);
		chk(r, exp, what);
	endtask : rd

	function automatic logic [11:0] lva(input int n, input logic [11:0] f);
		return `SMPM_LVL_BASE_OFS + `SMPM_LVL_STRIDE * 12'(n) + f;
	endfunction : lva

	// counts negedge samples until sensor_on shows lvl
	task wait_on(input logic lvl, input int lim, output int n);
		n = 0;
		@(negedge pclk);
		while (sensor_on !== lvl)
		begin
			n++;
			if (n >= lim)
				bail("sensor_on");
			@(negedge pclk);
		end
	endtask : wait_on

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset;
		rd(`SMPM_CTRL_OFS, 32'h0, "ctrl");
		rd(`SMPM_STAT_OFS, 32'h41, "stat");
		rd(`SMPM_IRQ_MASK_OFS, 32'h0, "mask");
		rd(`SMPM_REST_OFS, {16'h0, `SMPM_REST_RST}, "rest");
		for (int n = 0; n < 4; n++)
		begin
			rd(lva(n, `SMPM_LVL_SLEEP_OFS), {16'h0, `SMPM_SLEEP_RST}, "sleep");
			rd(lva(n, `SMPM_LVL_THR_OFS), {16'h0, `SMPM_THR_RST}, "thr");
			rd(lva(n, `SMPM_LVL_MODE_OFS), {16'h0, `SMPM_MODE_RST}, "mode");
		end
		rd(12'h02c, 32'h0, "unmapped read");
		chk(32'(e), 32'h1, "unmapped err");
		$display("reset test done");
	endtask : t_reset

	task t_lp_off;
		int n;
		n = 0;
		repeat (300) @(negedge pclk) n += int'(!sensor_on);
		chk(n, 0, "lp off sleeps");
		$display("lp off test done");
	endtask : t_lp_off

	// distinct values per level prove the four sets are independent
	task t_settings;
		apb(`SMPM_REST_OFS, 1'b1, 32'h2);
		for (int n = 0; n < 4; n++)
		begin
			apb(lva(n, `SMPM_LVL_SLEEP_OFS), 1'b1, 32'(3 + 16 * n));
			apb(lva(n, `SMPM_LVL_THR_OFS), 1'b1, 32'(5 + n));
		end
		for (int n = 0; n < 4; n++)
		begin
			rd(lva(n, `SMPM_LVL_SLEEP_OFS), 32'(3 + 16 * n), "sleep wr");
			rd(lva(n, `SMPM_LVL_THR_OFS), 32'(5 + n), "thr wr");
		end
		apb(`SMPM_CTRL_OFS, 1'b1, 32'h1);
		$display("settings test done");
	endtask : t_settings

	task t_cycle(input logic [15:0] mot, input logic wake);
		int n;
		@(posedge pclk);
		motion_mag <= 16'h0000;
		wait_on(1'b0, 400, n);
		rd(`SMPM_STAT_OFS, 32'h02, "inactive");
		@(posedge pclk);
		motion_mag <= mot;
		wait_on(1'b1, 60, n);
		chk(32'(n >= TCK && n <= 3 * TCK), 32'h1, "sleep span");
		n = 0;
		repeat (CHK + 3) @(negedge pclk) n += int'(sensor_on);
		chk(n, wake ? CHK + 3 : CHK - 1, "check span");
		rd(`SMPM_STAT_OFS, wake ? 32'h41 : 32'h02, "after check");
		apb(`SMPM_IRQ_STAT_OFS, 1'b0, 32'h0);
		chk(r[1:0], {wake, 1'b1}, "irq stat");
		apb(`SMPM_IRQ_STAT_OFS, 1'b1, 32'h3);
		$display("cycle test done");
	endtask : t_cycle

	task t_lp_exit;
		apb(`SMPM_CTRL_OFS, 1'b1, 32'h0);
		repeat (2) @(negedge pclk);
		chk(32'(sensor_on), 32'h1, "lp exit");
		apb(`SMPM_STAT_OFS, 1'b0, 32'h0);
		chk(r & 32'h47, 32'h41, "lp exit stat");
		$display("lp exit test done");
	endtask : t_lp_exit

	task t_step;
		int k;
		// motion left over from the last cycle test would keep the rest timer cleared
		@(posedge pclk);
		motion_mag <= 16'h0000;
		for (int n = 0; n < 4; n++)
		begin
			apb(lva(n, `SMPM_LVL_SLEEP_OFS), 1'b1, 32'd50);
			apb(lva(n, `SMPM_LVL_MODE_OFS), 1'b1, 32'd3);
		end
		apb(`SMPM_IRQ_STAT_OFS, 1'b1, 32'h7);
		apb(`SMPM_CTRL_OFS, 1'b1, 32'h1);
		// no register access while the levels step down
		for (int lv = 1; lv < 4; lv++)
		begin
			k = 0;
			while (sleep_level !== 2'(lv))
			begin
				@(negedge pclk);
				k++;
				if (k > 200)
					bail("level");
			end
		end
		k = 0;
		repeat (100) @(negedge pclk) k += int'(sleep_level !== 2'd3);
		chk(k, 0, "deepest held");
		chk(32'(irq), 32'h0, "irq masked");
		apb(`SMPM_IRQ_STAT_OFS, 1'b0, 32'h0);
		chk(r & 32'h4, 32'h4, "step irq");
		apb(`SMPM_IRQ_MASK_OFS, 1'b1, 32'h4);
		@(negedge pclk);
		chk(32'(irq), 32'h1, "irq raised");
		apb(`SMPM_IRQ_STAT_OFS, 1'b1, 32'h4);
		@(negedge pclk);
		chk(32'(irq), 32'h0, "irq cleared");
		$display("step test done");
	endtask : t_step

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		motion_mag = 16'h0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_lp_off;
		t_settings;
		t_cycle(16'h0000, 1'b0);
		t_cycle(16'h0001, 1'b1);
		apb(lva(0, `SMPM_LVL_THR_OFS), 1'b1, 32'd40);
		t_cycle(16'h0001, 1'b0);
		t_lp_exit;
		t_step;
		test_done;
	end
endmodule : tb_smpm_core
